// >>> logic/psp_stage.sv
`timescale 1ns/100ps
// How it works
// - The set level bounds the measured value, above for overcurrent or below for undervalue mode.
// - Every program cycle the set level is compared afresh with the measured value.
// - Once picked up, release needs the value past 97 percent of the set level, or past 103 percent in undervalue mode.
// - The blocking input is sampled at the start of each program cycle before pick-up is judged.
// - The block input is this stage's own line from the blocking matrix.
// - Pick-up with no block raises start and begins timing.
// - Pick-up under block raises the stage_flag_a flag instead; neither start nor timing follows.
// - A block clears start, and release runs as for a normal pick-up reset.
// - Pick-up under block emits a one-clock event carrying the captured value and fault type.
// - In definite-delay mode trip follows once the delay elapses with pick-up held.
// - The delay is counted in 5 ms steps, default 40 ms, and zero trips at once.
module psp_stage (
   input wire logic i_ref_clk,
   input wire logic i_rst_b,
   input wire logic [psp_pkg::MAG_W-1:0] i_meas,
   input wire logic [psp_pkg::MAG_W-1:0] i_set_level,
   input wire logic i_under_mode,
   input wire logic [1:0] i_unit_sel,
   input wire logic [1:0] i_fault_type,
   input wire logic i_block_in,
   input wire logic i_definite_delay_mode,
   input wire logic [psp_pkg::DLY_W-1:0] i_delay_steps,
   output logic o_start,
   output logic o_stage_flag_a,
   output logic o_trip,
   output logic o_block_event,
   output logic [psp_pkg::MAG_W-1:0] o_event_meas,
   output logic [1:0] o_event_fault,
   output logic [1:0] o_event_unit,
   output logic o_cycle
);
   // ***************************************************************
   // Program cycle and input sampling
   // ***************************************************************
   logic tick;
   logic blk_s1;
   logic blk_s2;
   logic blk_cyc;

   // The tick is the only timebase; every decision below waits for it.
   psp_cycle_tick u_tick (
      .i_ref_clk(i_ref_clk),
      .i_rst_b(i_rst_b),
      .o_tick(tick)
   );

   // The dedicated matrix line crosses in from outside and is
   // synchronised; the decisions below read it only on the tick, so
   // each program cycle judges the value present as it begins.
   // Two flops cost two clocks of latency, which is negligible beside
   // the margin the blocking source must give ahead of a trip.
   assign blk_cyc = blk_s2;

   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_b) begin
         blk_s1 <= 1'b0;
         blk_s2 <= 1'b0;
      end else begin
         blk_s1 <= i_block_in;
         blk_s2 <= blk_s1;
      end
   end

   // ***************************************************************
   // Level comparison
   // ***************************************************************
   // Products are widened so the 97 percent scaling never overflows.
   logic [psp_pkg::MAG_W+6:0] meas_x100;
   logic [psp_pkg::MAG_W+6:0] set_x100;
   logic [psp_pkg::MAG_W+6:0] set_x97;
   logic over_pick;
   logic over_hold;
   logic pick_now;
   logic hold_now;

   assign meas_x100 = (psp_pkg::MAG_W+7)'(i_meas) *
      (psp_pkg::MAG_W+7)'(psp_pkg::PCT_FULL);
   assign set_x100 = (psp_pkg::MAG_W+7)'(i_set_level) *
      (psp_pkg::MAG_W+7)'(psp_pkg::PCT_FULL);
   assign set_x97 = (psp_pkg::MAG_W+7)'(i_set_level) *
      (psp_pkg::MAG_W+7)'(psp_pkg::RESET_PCT);
   // The unit selector only tags events; the compare is unit-free
   // because both values arrive scaled alike.
   // Equality is not a pick-up: the value must pass the set level.
   assign over_pick = meas_x100 > set_x100;
   assign over_hold = meas_x100 > set_x97;
   // An undervalue stage releases above the set level, so its
   // hysteresis is mirrored to 103 percent.
   assign pick_now = i_under_mode ? (meas_x100 < set_x100) : over_pick;
   assign hold_now = i_under_mode ?
      (meas_x100 < (set_x100 + set_x100 - set_x97)) : over_hold;

   // ***************************************************************
   // Stage sequence
   // ***************************************************************
   psp_pkg::psp_state_type state;
   psp_pkg::psp_state_type next_state;
   logic [psp_pkg::DLY_W-1:0] steps;
   logic [psp_pkg::DLY_W-1:0] next_steps;
   logic [7:0] sub;
   logic [7:0] next_sub;
   logic next_trip;
   logic next_event;
   logic [psp_pkg::MAG_W-1:0] next_ev_meas;
   logic [1:0] next_ev_fault;
   logic [1:0] next_ev_unit;
   logic active;
   logic next_start;
   logic next_flag;

   // Hysteresis applies only once the stage has left idle.
   assign active = (state != psp_pkg::ST_IDLE) ?
      hold_now : pick_now;

   assign next_start = (next_state == psp_pkg::ST_START);
   assign next_flag = (next_state == psp_pkg::ST_BLOCK);

   always_comb begin
      next_state = state;
      next_steps = steps;
      next_sub = sub;
      next_trip = o_trip;
      next_event = 1'b0;
      next_ev_meas = o_event_meas;
      next_ev_fault = o_event_fault;
      next_ev_unit = o_event_unit;
      if (tick) begin
         // No default: the state register only holds the three codes.
         unique case (state)
            psp_pkg::ST_IDLE: begin
               if (pick_now && blk_cyc) begin
                  next_state = psp_pkg::ST_BLOCK;
                  next_event = 1'b1;
                  // The payload is captured here and held, so a late
                  // reader still sees the values of the last event.
                  next_ev_meas = i_meas;
                  next_ev_fault = i_fault_type;
                  next_ev_unit = i_unit_sel;
               end else if (pick_now) begin
                  next_state = psp_pkg::ST_START;
               end
            end
            psp_pkg::ST_START: begin
               if (!active || blk_cyc) begin
                  // Same release path for block and value reset.
                  next_state = psp_pkg::ST_IDLE;
                  next_trip = 1'b0;
               end
            end
            // A stage_flag_a stage stays stage_flag_a until the value releases,
            // even if the block lifts first; it never starts from here.
            psp_pkg::ST_BLOCK: begin
               if (!active) begin
                  next_state = psp_pkg::ST_IDLE;
               end
            end
         endcase
      end
      // Any exit from start drops the count, so a re-pick times from zero.
      if (next_state != psp_pkg::ST_START) begin
         next_steps = '0;
         next_sub = 8'h00;
      end else if (tick && state == psp_pkg::ST_START) begin
         // Stepping stops at the target; the trip latches there.
         if (steps < i_delay_steps) begin
            if (sub == 8'(psp_pkg::STEP_CYCLES - 1)) begin
               next_sub = 8'h00;
               next_steps = steps + 19'h0_0001;
            end else begin
               next_sub = sub + 8'h01;
            end
         end
      end
      // Trip is judged on the tick only, so a delay setting changed
      // inside a program cycle takes effect at the next one.
      if (tick && next_state == psp_pkg::ST_START &&
         i_definite_delay_mode && next_steps >= i_delay_steps) begin
         next_trip = 1'b1;
      end
      // Trip stays latched until start drops, whatever the mode does.
      if (next_state != psp_pkg::ST_START) begin
         next_trip = 1'b0;
      end
   end

   // ***************************************************************
   // Output registers
   // ***************************************************************
   // Every output leaves a flip-flop, so a reader never sees the
   // combinational decode settle.
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_b) begin
         state <= psp_pkg::ST_IDLE;
         steps <= '0;
         sub <= 8'h00;
         o_trip <= 1'b0;
         o_start <= 1'b0;
         o_stage_flag_a <= 1'b0;
         o_block_event <= 1'b0;
         o_event_meas <= '0;
         o_event_fault <= 2'h0;
         o_event_unit <= psp_pkg::UNIT_PU;
         o_cycle <= 1'b0;
      end else begin
         state <= next_state;
         steps <= next_steps;
         sub <= next_sub;
         o_trip <= next_trip;
         o_start <= next_start;
         o_stage_flag_a <= next_flag;
         o_block_event <= next_event;
         o_event_meas <= next_ev_meas;
         o_event_fault <= next_ev_fault;
         o_event_unit <= next_ev_unit;
         o_cycle <= tick;
      end
   end
endmodule : psp_stage

// >>> pkg/psp_pkg.sv
package psp_pkg;
   // ***************************************************************
   // Widths and timing
   // ***************************************************************
   localparam int MAG_W = 16;
   localparam int DLY_W = 19;
   localparam int CLK_HZ = 100_000_000;
   // Program cycle time in microseconds.
   localparam int CYCLE_US = 1000;
   localparam int CYCLE_CLKS = CYCLE_US * (CLK_HZ / 1_000_000);
   // Delay step of the definite-time setting in milliseconds.
   localparam int DLY_STEP_MS = 5;
   localparam int DLY_DEFAULT_MS = 40;
   localparam logic [DLY_W-1:0] DLY_DEFAULT_STEPS =
      DLY_W'(DLY_DEFAULT_MS / DLY_STEP_MS);
   localparam int STEP_CYCLES = DLY_STEP_MS * 1000 / CYCLE_US;
   // Reset ratio in percent of the set level.
   localparam int RESET_PCT = 97;
   localparam int PCT_FULL = 100;
   localparam logic [1:0] UNIT_PU = 2'h0;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_START = 3'b010,
      ST_BLOCK = 3'b100
   } psp_state_type;
endpackage : psp_pkg

// >>> logic/psp_cycle_tick.sv
`timescale 1ns/100ps
module psp_cycle_tick (
   input wire logic i_ref_clk,
   input wire logic i_rst_b,
   output logic o_tick
);
   logic [31:0] cnt;
   logic [31:0] next_cnt;
   logic next_tick;

   always_comb begin
      next_tick = 1'b0;
      next_cnt = cnt + 32'h0000_0001;
      if (cnt == 32'(psp_pkg::CYCLE_CLKS - 1)) begin
         next_cnt = 32'h0000_0000;
         next_tick = 1'b1;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_b) begin
         cnt <= 32'h0000_0000;
         o_tick <= 1'b0;
      end else begin
         cnt <= next_cnt;
         o_tick <= next_tick;
      end
   end
endmodule : psp_cycle_tick

// >>> sim/psp_stage_chk.sv
`timescale 1ns/100ps
// ***************************************************************
// Stage port checker
// ***************************************************************
module psp_stage_chk (
   input wire logic i_ref_clk,
   input wire logic i_rst_b,
   input wire logic [psp_pkg::MAG_W-1:0] i_meas,
   input wire logic [psp_pkg::MAG_W-1:0] i_set_level,
   input wire logic i_under_mode,
   input wire logic [1:0] i_fault_type,
   input wire logic i_block_in,
   input wire logic o_start,
   input wire logic o_stage_flag_a,
   input wire logic o_trip,
   input wire logic o_block_event,
   input wire logic [psp_pkg::MAG_W-1:0] o_event_meas,
   input wire logic [1:0] o_event_fault,
   input wire logic o_cycle
);
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (!i_rst_b);
   sequence blk_raise_s;
      o_cycle ##0 o_stage_flag_a ##0 o_block_event;
   endsequence
   start_step_a: assert property (
      !o_cycle |-> $stable(o_start)) else $error("start moved");
   flag_step_a: assert property (
      !o_cycle |-> $stable(o_stage_flag_a)) else $error("flag moved");
   one_state_a: assert property (
      !(o_start && o_stage_flag_a)) else $error("start and flag");
   pick_cause_a: assert property (
      $rose(o_start) |-> !$past(i_block_in, 3) && ($past(i_under_mode) ?
      $past(i_meas) < $past(i_set_level) :
      $past(i_meas) > $past(i_set_level))) else $error("bad start");
   blk_cause_a: assert property (
      $rose(o_stage_flag_a) |-> $past(i_block_in, 3))
      else $error("bad block");
   block_event_a: assert property (
      $rose(o_stage_flag_a) |-> blk_raise_s) else $error("no event");
   event_pulse_a: assert property (
      o_block_event |=> !o_block_event) else $error("event too long");
   payload_a: assert property (
      o_block_event |-> o_event_meas == $past(i_meas) &&
      o_event_fault == $past(i_fault_type)) else $error("bad payload");
   no_direct_a: assert property (
      o_stage_flag_a |=> !o_start) else $error("stage_flag_a to start");
   trip_start_a: assert property (
      o_trip |-> o_start) else $error("trip without start");
   trip_step_a: assert property (
      $rose(o_trip) |-> o_cycle) else $error("trip off cycle");
endmodule : psp_stage_chk

// >>> sim/psp_front_model.sv
`timescale 1ns/100ps
module psp_front_model (
   input wire logic i_ref_clk,
   input wire logic [psp_pkg::MAG_W-1:0] i_level,
   input wire logic i_block_req,
   output logic [psp_pkg::MAG_W-1:0] o_meas,
   output logic o_block
);
   initial begin
      o_meas = 16'h0000;
      o_block = 1'b0;
   end
   // Lines move after the falling edge, well clear of the sampling edge.
   always @(negedge i_ref_clk) begin
      o_meas <= i_level;
      o_block <= i_block_req;
   end
endmodule : psp_front_model

// >>> sim/test_psp_stage.sv
`timescale 1ns/100ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin bad_count++; \
   $display("[ERR] t=%0t got %h exp %h", $time, (a), (b)); end end
module test_psp_stage;
   logic i_ref_clk = 1'b0;
   logic i_rst_b = 1'b0;
   logic [psp_pkg::MAG_W-1:0] level = 16'h0000;
   logic [psp_pkg::MAG_W-1:0] set_lvl = 16'h03e8;
   logic [1:0] unit = 2'h1;
   logic [psp_pkg::MAG_W-1:0] i_meas;
   logic [psp_pkg::DLY_W-1:0] steps = 19'h0_0000;
   logic under = 1'b0;
   logic blk_req = 1'b0;
   logic dmode = 1'b1;
   logic i_block_in;
   logic o_start, o_stage_flag_a, o_trip, o_block_event, o_cycle;
   logic [psp_pkg::MAG_W-1:0] o_event_meas;
   logic [1:0] o_event_fault, o_event_unit;
   int bad_count = 0;
   int comparisons = 0;
   initial begin
      forever #5 i_ref_clk = ~i_ref_clk;
   end
   psp_front_model fm (.i_ref_clk(i_ref_clk), .i_level(level),
      .i_block_req(blk_req), .o_meas(i_meas), .o_block(i_block_in));
   psp_stage dut (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b),
      .i_meas(i_meas), .i_set_level(set_lvl), .i_under_mode(under),
      .i_unit_sel(unit), .i_fault_type(2'h2), .i_block_in(i_block_in),
      .i_definite_delay_mode(dmode), .i_delay_steps(steps),
      .o_start(o_start), .o_stage_flag_a(o_stage_flag_a), .o_trip(o_trip),
      .o_block_event(o_block_event), .o_event_meas(o_event_meas),
      .o_event_fault(o_event_fault), .o_event_unit(o_event_unit),
      .o_cycle(o_cycle));
   // ***************************************************************
   // Access tasks
   // ***************************************************************
   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : end_of_test
   // A lost cycle pulse would hang the run, so every wait is bounded.
   task automatic cycles(input int n);
      int k;
      repeat (n) begin
         k = 0;
         do begin
            @(negedge i_ref_clk);
            k++;
         end while (o_cycle !== 1'b1 && k < 100_100);
         if (k >= 100_100) begin
            bad_count++;
            end_of_test();
         end
      end
   endtask : cycles
   task automatic expect3(input logic s, f, t, input string name);
      `CHK(o_start, s)
      `CHK(o_stage_flag_a, f)
      `CHK(o_trip, t)
      $display("test %s done", name);
   endtask : expect3
   // ***************************************************************
   // Sequence
   // ***************************************************************
   initial begin
      repeat (16) @(negedge i_ref_clk);
      i_rst_b = 1'b1;
      expect3(1'b0, 1'b0, 1'b0, "reset");
      level = 16'h044c;
      cycles(1);
      expect3(1'b1, 1'b0, 1'b1, "instant");
      level = 16'h03d4;
      cycles(1);
      expect3(1'b1, 1'b0, 1'b1, "hold");
      level = 16'h03c0;
      cycles(1);
      expect3(1'b0, 1'b0, 1'b0, "release");
      steps = 19'h0_0001;
      level = 16'h044c;
      cycles(psp_pkg::STEP_CYCLES);
      expect3(1'b1, 1'b0, 1'b0, "delay_pre");
      cycles(1);
      expect3(1'b1, 1'b0, 1'b1, "delay");
      blk_req = 1'b1;
      cycles(1);
      expect3(1'b0, 1'b0, 1'b0, "block_clear");
      cycles(1);
      `CHK(o_block_event, 1'b1)
      `CHK(o_event_meas, 16'h044c)
      `CHK(o_event_fault, 2'h2)
      `CHK(o_event_unit, 2'h1)
      expect3(1'b0, 1'b1, 1'b0, "stage_flag_a");
      level = 16'h03c0;
      cycles(1);
      `CHK(o_block_event, 1'b0)
      expect3(1'b0, 1'b0, 1'b0, "block_release");
      blk_req = 1'b0;
      dmode = 1'b0;
      under = 1'b1;
      steps = 19'h0_0000;
      set_lvl = 16'h0400;
      level = 16'h0384;
      cycles(1);
      expect3(1'b1, 1'b0, 1'b0, "under");
      level = 16'h0410;
      cycles(1);
      expect3(1'b1, 1'b0, 1'b0, "under_hold");
      end_of_test();
   end
endmodule : test_psp_stage
bind psp_stage psp_stage_chk chk (.i_ref_clk, .i_rst_b, .i_meas,
   .i_set_level, .i_under_mode, .i_fault_type, .i_block_in, .o_start,
   .o_stage_flag_a, .o_trip, .o_block_event, .o_event_meas,
   .o_event_fault, .o_cycle);
